//--- core/tcw_channel.sv
// Timer channel in waveform mode with its APB register file.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module tcw_channel (
  // APB clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // External clock inputs
  input  wire logic        ext_clock_in_0,
  input  wire logic        ext_clock_in_1,
  input  wire logic        ext_clock_in_2,
  // Channel line A (output, enable low drives)
  output logic             channel_line_a_o,
  output logic             channel_line_a_oe_n,
  // Channel line B (two-way)
  input  wire logic        channel_line_b_i,
  output logic             channel_line_b_o,
  output logic             channel_line_b_oe_n
);
  import tcw_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [31:0] mode_r;
  logic [15:0] count_r;
  logic [15:0] cmpa_r;
  logic [15:0] cmpb_r;
  logic [15:0] cmpc_r;
  logic        clk_en_r;
  logic        stopped_r;
  logic        line_a_r;
  logic        line_b_r;
  logic        clk_prev_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        a_oe_n_r;
  logic        b_oe_n_r;

  // ---------------------------------------------------------------
  // Mode field decode
  // ---------------------------------------------------------------
  wire [2:0] clk_sel    = mode_r[TCW_M_CLKSEL +: 3];
  wire       clock_edge_invert = mode_r[TCW_M_CLKINV];
  wire [1:0] gate_sel   = mode_r[TCW_M_GATE +: 2];
  wire       stop_on_period_match    = mode_r[TCW_M_STOP];
  wire       disable_on_period_match = mode_r[TCW_M_DIS];
  wire [1:0] event_edge_select  = mode_r[TCW_M_EVEDGE +: 2];
  wire [1:0] event_input_select = mode_r[TCW_M_EVSRC +: 2];
  wire       event_trigger_enable        = mode_r[TCW_M_EVTRIG];
  wire       period_match_trigger_enable = mode_r[TCW_M_PERTRIG];
  wire       wave_mode = mode_r[TCW_M_WAVE];
  wire [1:0] line_a_on_match_a      = mode_r[TCW_M_A_MA +: 2];
  wire [1:0] line_a_on_period_match = mode_r[TCW_M_A_PC +: 2];
  wire [1:0] line_a_on_event        = mode_r[TCW_M_A_EV +: 2];
  wire [1:0] line_a_on_soft_trigger = mode_r[TCW_M_A_SW +: 2];
  wire [1:0] line_b_on_match_b      = mode_r[TCW_M_B_MB +: 2];
  wire [1:0] line_b_on_period_match = mode_r[TCW_M_B_PC +: 2];
  wire [1:0] line_b_on_event        = mode_r[TCW_M_B_EV +: 2];
  wire [1:0] line_b_on_soft_trigger = mode_r[TCW_M_B_SW +: 2];

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  wire wr_acc  = psel & penable & pwrite & pready_r;
  wire rd_setup = psel & ~penable;
  wire hit_ctrl = (paddr == TCW_OFF_CTRL);
  wire hit_mode = (paddr == TCW_OFF_MODE);
  wire hit_cnt  = (paddr == TCW_OFF_COUNT);
  wire hit_a    = (paddr == TCW_OFF_CMPA);
  wire hit_b    = (paddr == TCW_OFF_CMPB);
  wire hit_c    = (paddr == TCW_OFF_CMPC);
  wire hit_st   = (paddr == TCW_OFF_STAT);
  wire mapped   = hit_ctrl | hit_mode | hit_cnt | hit_a | hit_b | hit_c | hit_st;
  wire cmd_en   = wr_acc & hit_ctrl & pwdata[TCW_CMD_CLKEN];
  wire cmd_dis  = wr_acc & hit_ctrl & pwdata[TCW_CMD_CLKDIS];
  wire soft_trigger_command = wr_acc & hit_ctrl & pwdata[TCW_CMD_SWTRIG];
  wire wr_mode  = wr_acc & hit_mode;
  wire wr_a     = wr_acc & hit_a & wave_mode;
  wire wr_b     = wr_acc & hit_b & wave_mode;
  wire wr_c     = wr_acc & hit_c;

  // ---------------------------------------------------------------
  // Counter clock selection, gating and edge
  // ---------------------------------------------------------------
  logic presc_tick;
  tcw_prescale u_presc (
    .pclk    (pclk),
    .presetn (presetn),
    .sel     (clk_sel),
    .tick    (presc_tick)
  );
  wire ext_sel = (clk_sel == 3'h5) ? ext_clock_in_0 :
                 (clk_sel == 3'h6) ? ext_clock_in_1 : ext_clock_in_2;
  wire gate_lvl = (gate_sel == 2'h1) ? ext_clock_in_0 :
                  (gate_sel == 2'h2) ? ext_clock_in_1 :
                  (gate_sel == 2'h3) ? ext_clock_in_2 : 1'b1;
  wire clk_lvl  = ext_sel & gate_lvl;
  wire ext_rise = clk_lvl & ~clk_prev_r;
  wire ext_fall = ~clk_lvl & clk_prev_r;
  wire ext_step = clock_edge_invert ? ext_fall : ext_rise;
  wire int_step = presc_tick & gate_lvl;
  wire src_step = clk_sel[2] & (clk_sel != 3'h4) ? ext_step : int_step;
  wire step     = src_step & clk_en_r & ~stopped_r & wave_mode;

  // ---------------------------------------------------------------
  // External event source and edge detection
  // ---------------------------------------------------------------
  wire b_is_input = (event_input_select == 2'h0);
  wire ev_lvl = (event_input_select == 2'h1) ? ext_clock_in_0 :
                (event_input_select == 2'h2) ? ext_clock_in_1 :
                (event_input_select == 2'h3) ? ext_clock_in_2 : channel_line_b_i;
  logic ev_hit;
  tcw_edge u_ev (
    .pclk    (pclk),
    .presetn (presetn),
    .level   (ev_lvl),
    .sel     (event_edge_select),
    .hit     (ev_hit)
  );
  wire event_fire = ev_hit & wave_mode;

  // ---------------------------------------------------------------
  // Compare matches and triggers
  // ---------------------------------------------------------------
  wire [15:0] count_inc = count_r + 16'h0001;
  wire match_a = step & (count_inc == cmpa_r);
  wire match_b = step & (count_inc == cmpb_r);
  wire match_c = step & (count_inc == cmpc_r);
  wire ev_trig = event_fire & event_trigger_enable;
  wire pc_trig = match_c & period_match_trigger_enable;
  wire restart = soft_trigger_command | ev_trig | pc_trig;

  // Next counter: a trigger resets it, otherwise an enabled step counts.
  wire [15:0] count_nxt = restart ? TCW_VAL_RST : (step ? count_inc : count_r);

  // Clock enable: disable wins over enable; triggers restart the clock.
  wire clk_en_nxt = (cmd_dis | (match_c & disable_on_period_match)) ? 1'b0 :
                    (cmd_en | restart) ? 1'b1 : clk_en_r;
  // A stopping match wins over a trigger or enable that lands in the same cycle.
  wire stop_nxt = (match_c & stop_on_period_match) ? 1'b1 :
                  (restart | cmd_en) ? 1'b0 : stopped_r;

  // ---------------------------------------------------------------
  // Line actions, lowest to highest priority: match, event, software
  // ---------------------------------------------------------------
  wire a_s1 = match_a ? tcw_apply(line_a_on_match_a, line_a_r) : line_a_r;
  wire a_s2 = match_c ? tcw_apply(line_a_on_period_match, a_s1) : a_s1;
  wire a_s3 = event_fire ? tcw_apply(line_a_on_event, a_s2) : a_s2;
  wire a_nxt = soft_trigger_command ? tcw_apply(line_a_on_soft_trigger, a_s3) : a_s3;
  wire b_s1 = match_b ? tcw_apply(line_b_on_match_b, line_b_r) : line_b_r;
  wire b_s2 = match_c ? tcw_apply(line_b_on_period_match, b_s1) : b_s1;
  wire b_s3 = event_fire ? tcw_apply(line_b_on_event, b_s2) : b_s2;
  wire b_nxt = soft_trigger_command ? tcw_apply(line_b_on_soft_trigger, b_s3) : b_s3;

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  wire [31:0] stat_w = {13'h0000, line_b_r, line_a_r, clk_en_r & ~stopped_r, 16'h0000};
  wire [31:0] rd_mux = hit_mode ? mode_r :
                       hit_cnt  ? {16'h0000, count_r} :
                       hit_a    ? {16'h0000, cmpa_r} :
                       hit_b    ? {16'h0000, cmpb_r} :
                       hit_c    ? {16'h0000, cmpc_r} :
                       hit_st   ? stat_w : 32'h0000_0000;

  // Mode and compare registers; upper write bits are dropped for the compare registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= TCW_MODE_RST;
      cmpa_r <= TCW_VAL_RST;
      cmpb_r <= TCW_VAL_RST;
      cmpc_r <= TCW_VAL_RST;
    end else begin
      if (wr_mode) mode_r <= pwdata;
      if (wr_a) cmpa_r <= pwdata[15:0];
      if (wr_b) cmpb_r <= pwdata[15:0];
      if (wr_c) cmpc_r <= pwdata[15:0];
    end
  end

  // Counter, clock state and edge history.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r    <= TCW_VAL_RST;
      clk_en_r   <= 1'b0;
      stopped_r  <= 1'b0;
      clk_prev_r <= 1'b0;
    end else begin
      count_r    <= count_nxt;
      clk_en_r   <= clk_en_nxt;
      stopped_r  <= stop_nxt;
      clk_prev_r <= clk_lvl;
    end
  end

  // Channel lines and their drive enables.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_a_r <= 1'b0;
      line_b_r <= 1'b0;
      a_oe_n_r <= 1'b1;
      b_oe_n_r <= 1'b1;
    end else begin
      line_a_r <= a_nxt;
      line_b_r <= b_nxt;
      a_oe_n_r <= ~wave_mode;
      b_oe_n_r <= ~wave_mode | b_is_input;
    end
  end

  // APB answer: one wait state, data taken at the access edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= psel & penable & ~pready_r;
      pslverr_r <= psel & penable & ~pready_r & ~mapped;
      if (rd_setup | (psel & penable & ~pready_r)) prdata_r <= mapped ? rd_mux : 32'h0000_0000;
    end
  end

  assign prdata              = prdata_r;
  assign pready              = pready_r;
  assign pslverr             = pslverr_r;
  assign channel_line_a_o    = line_a_r;
  assign channel_line_a_oe_n = a_oe_n_r;
  assign channel_line_b_o    = line_b_r;
  assign channel_line_b_oe_n = b_oe_n_r;
endmodule

//--- core/tcw_edge.sv
// Edge detector with selectable edge sense for one sampled level.
`timescale 1ns/1ps
module tcw_edge (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Level and selection
  input  wire logic       level,
  input  wire logic [1:0] sel,
  // Detected edge pulse
  output logic            hit
);
  import tcw_pkg::*;

  logic prev_r;
  wire  rise = level & ~prev_r;
  wire  fall = ~level & prev_r;

  // Select which edges count: none, rising, falling or both.
  assign hit = (sel == 2'h1) ? rise : (sel == 2'h2) ? fall : (sel == 2'h3) ? (rise | fall) : 1'b0;

  // Remember the previous level.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= level;
    end
  end
endmodule

//--- core/tcw_pkg.sv
// Package of constants and types for the waveform-mode timer channel.
// Notes on behaviour
// - Clock invert picks rising or falling count edge
// - Gating field ANDs ext clock 0/1/2 in
// - Stop bit halts clock on period match
// - Disable bit disables clock on period match
// - Event edge field: none, rise, fall, both
// - Event source: line B or ext clocks
// - Line B as event source becomes input
// - Event trigger resets counter, starts clock
// - Period trigger resets counter, starts clock
// - Mode bit selects pattern or capture mode
// - Match A acts on line A
// - Period match acts on line A
// - External event acts on line A
// - Software trigger acts on line A
// - Match B acts on line B
// - Period match acts on line B
// - External event acts on line B
// - Software trigger acts on line B
// - Count value register reads live count
// - Compare A writable only in pattern mode
// - Compare B writable only in pattern mode
// - Period compare C always read/write
// - Soft trigger resets counter, starts clock
package tcw_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] TCW_OFF_CTRL  = 8'h00;
  localparam logic [7:0] TCW_OFF_MODE  = 8'h04;
  localparam logic [7:0] TCW_OFF_COUNT = 8'h10;
  localparam logic [7:0] TCW_OFF_CMPA  = 8'h14;
  localparam logic [7:0] TCW_OFF_CMPB  = 8'h18;
  localparam logic [7:0] TCW_OFF_CMPC  = 8'h1C;
  localparam logic [7:0] TCW_OFF_STAT  = 8'h20;
  // ---------------------------------------------------------------
  // Control command bits
  // ---------------------------------------------------------------
  localparam int TCW_CMD_CLKEN  = 0;
  localparam int TCW_CMD_CLKDIS = 1;
  localparam int TCW_CMD_SWTRIG = 2;
  // ---------------------------------------------------------------
  // Mode field positions
  // ---------------------------------------------------------------
  localparam int TCW_M_CLKSEL  = 0;
  localparam int TCW_M_CLKINV  = 3;
  localparam int TCW_M_GATE    = 4;
  localparam int TCW_M_STOP    = 6;
  localparam int TCW_M_DIS     = 7;
  localparam int TCW_M_EVEDGE  = 8;
  localparam int TCW_M_EVSRC   = 10;
  localparam int TCW_M_EVTRIG  = 12;
  localparam int TCW_M_PERTRIG = 14;
  localparam int TCW_M_WAVE    = 15;
  localparam int TCW_M_A_MA    = 16;
  localparam int TCW_M_A_PC    = 18;
  localparam int TCW_M_A_EV    = 20;
  localparam int TCW_M_A_SW    = 22;
  localparam int TCW_M_B_MB    = 24;
  localparam int TCW_M_B_PC    = 26;
  localparam int TCW_M_B_EV    = 28;
  localparam int TCW_M_B_SW    = 30;
  // ---------------------------------------------------------------
  // Status bit positions and reset values
  // ---------------------------------------------------------------
  localparam int TCW_S_CLKON = 16;
  localparam int TCW_S_LINEA = 17;
  localparam int TCW_S_LINEB = 18;
  localparam logic [31:0] TCW_MODE_RST = 32'h0000_0000;
  localparam logic [15:0] TCW_VAL_RST  = 16'h0000;
  // ---------------------------------------------------------------
  // Internal prescaler divisors
  // ---------------------------------------------------------------
  localparam int TCW_DIV_W = 10;
  localparam logic [TCW_DIV_W-1:0] TCW_DIV2    = 10'h001;
  localparam logic [TCW_DIV_W-1:0] TCW_DIV8    = 10'h007;
  localparam logic [TCW_DIV_W-1:0] TCW_DIV32   = 10'h01F;
  localparam logic [TCW_DIV_W-1:0] TCW_DIV128  = 10'h07F;
  localparam logic [TCW_DIV_W-1:0] TCW_DIV1024 = 10'h3FF;
  // Line action codes.
  typedef enum logic [1:0] {
    TCW_ACT_NONE = 2'h0, TCW_ACT_SET = 2'h1, TCW_ACT_CLR = 2'h2, TCW_ACT_TGL = 2'h3
  } tcw_act_type;
  // Apply one two-bit action to a line level.
  function automatic logic tcw_apply(input logic [1:0] act, input logic lvl);
    case (act)
      2'h1:    tcw_apply = 1'b1;
      2'h2:    tcw_apply = 1'b0;
      2'h3:    tcw_apply = ~lvl;
      default: tcw_apply = lvl;
    endcase
  endfunction
endpackage

//--- core/tcw_prescale.sv
// Free-running divider of the bus clock giving prescaler enable pulses.
`timescale 1ns/1ps
module tcw_prescale (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Selection of the internal divisor
  input  wire logic [2:0] sel,
  // One-cycle tick
  output logic            tick
);
  import tcw_pkg::*;

  logic [TCW_DIV_W-1:0] cnt_r;
  wire  [TCW_DIV_W-1:0] lim = (sel == 3'h0) ? TCW_DIV2 :
                              (sel == 3'h1) ? TCW_DIV8 :
                              (sel == 3'h2) ? TCW_DIV32 :
                              (sel == 3'h3) ? TCW_DIV128 : TCW_DIV1024;

  // Tick when the shared counter wraps at the selected mask.
  assign tick = ((cnt_r & lim) == lim);

  // Count bus clock cycles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule

//--- sim/tcw_checker.sv
// Concurrent checks on the bus and line ports of the timer channel.
`timescale 1ns/1ps
module tcw_checker (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB slave side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Line enables
  input wire logic        channel_line_a_oe_n,
  input wire logic        channel_line_b_oe_n
);
  import tcw_pkg::*;
  logic [31:0] mode_r;
  logic [15:0] cmp_r [3];
  logic        done;
  logic        wr_mode;
  logic        is_cmp;
  logic        mapped;
  logic [1:0]  idx;
  // Decode of completed transfers and of the compare register slots.
  assign done    = psel && penable && pready;
  assign wr_mode = done && pwrite && (paddr == TCW_OFF_MODE);
  assign is_cmp  = (paddr[7:4] == 4'h1) && (paddr[3:2] != 2'h0) && (paddr[1:0] == 2'h0);
  assign idx     = paddr[3:2] - 2'h1;
  assign mapped  = paddr inside {8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
  // Shadow copies of mode and compare registers, fed by completed writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= 32'h0;
      cmp_r  <= '{default: 16'h0};
    end else if (done && pwrite) begin
      if (wr_mode) mode_r <= pwdata;
      if (is_cmp && (idx == 2'h2 || mode_r[TCW_M_WAVE])) cmp_r[idx] <= pwdata[15:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_one_wait;
    (penable && !pready) ##1 pready;
  endsequence
  a_one_wait: assert property (s_setup |=> s_one_wait)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_unmapped: assert property (done && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_count_upper: assert property (done && !pwrite && paddr == TCW_OFF_COUNT |-> prdata[31:16] == 16'h0)
    else $error("count upper half not zero");
  a_cmp_readback: assert property (done && !pwrite && is_cmp |-> prdata == {16'h0, cmp_r[idx]})
    else $error("compare register read wrong");
  a_b_direction: assert property ((!wr_mode)[*2] |-> channel_line_b_oe_n == !(mode_r[15] && mode_r[11:10] != 2'h0))
    else $error("line b direction wrong");
  a_a_drive: assert property ((!wr_mode)[*2] |-> channel_line_a_oe_n == !mode_r[TCW_M_WAVE])
    else $error("line a enable wrong");
endmodule
bind tcw_channel tcw_checker chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .channel_line_a_oe_n, .channel_line_b_oe_n);

//--- sim/tcw_pins.sv
// Far-side model: external clock sources and the pin of channel line B.
`timescale 1ns/1ps
module tcw_pins (
  // Clock
  input wire logic       pclk,
  // Levels requested by the bench
  input wire logic [2:0] xc_req,
  input wire logic       b_req,
  // Line B as driven by the channel
  input wire logic       b_o,
  input wire logic       b_oe_n,
  // Levels seen by the channel
  output logic           xc0,
  output logic           xc1,
  output logic           xc2,
  output logic           b_pin
);
  logic [2:0] xc_r = 3'h0;
  // External clocks change on the bus clock, as the channel expects them.
  always_ff @(posedge pclk) xc_r <= xc_req;
  assign {xc2, xc1, xc0} = xc_r;
  // The channel owns the pin while its enable is low, the source otherwise.
  assign b_pin = b_oe_n ? b_req : b_o;
endmodule

//--- sim/testbench.sv
// Self-checking bench for the waveform-mode timer channel.
`timescale 1ns/1ps
module testbench;
  import tcw_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0]  xc_req;
  logic        b_req, xc0, xc1, xc2, b_pin, a_o, a_oe_n, b_o, b_oe_n;
  int          err_total, total_checks, cycles;
  tcw_channel dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_clock_in_0(xc0), .ext_clock_in_1(xc1), .ext_clock_in_2(xc2),
    .channel_line_a_o(a_o), .channel_line_a_oe_n(a_oe_n), .channel_line_b_i(b_pin),
    .channel_line_b_o(b_o), .channel_line_b_oe_n(b_oe_n));
  tcw_pins pins_u (.pclk(pclk), .xc_req(xc_req), .b_req(b_req), .b_o(b_o), .b_oe_n(b_oe_n),
    .xc0(xc0), .xc1(xc1), .xc2(xc2), .b_pin(b_pin));
  // Bus clock of 100 ns.
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Cuts a hung run short.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer; the request stands until pready is sampled high or 16 access cycles pass.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    chk("pready", 32'h1, 32'(pready));
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(what, exp, r);
  endtask
  // Pulses one external clock n times, then lets the result settle.
  task automatic pulse(input int i, input int n);
    repeat (n) begin
      @(posedge pclk);
      xc_req[i] <= 1'b1;
      repeat (4) @(posedge pclk);
      xc_req[i] <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    repeat (6) @(posedge pclk);
  endtask
  task automatic t_regs();
    logic [31:0] r;
    logic        e;
    rd(TCW_OFF_COUNT, 32'h0, "count reset");
    rd(TCW_OFF_CMPA, 32'h0, "cmp a reset");
    rd(TCW_OFF_CMPB, 32'h0, "cmp b reset");
    rd(TCW_OFF_CMPC, 32'h0, "cmp c reset");
    apb(1'b0, 8'h08, 32'h0, r, e);
    chk("unmapped error", 32'h1, 32'(e));
    wr(TCW_OFF_CMPA, 32'hFFFF_1234);
    rd(TCW_OFF_CMPA, 32'h0, "cmp a capture");
    wr(TCW_OFF_CMPB, 32'h5678);
    rd(TCW_OFF_CMPB, 32'h0, "cmp b capture");
    wr(TCW_OFF_CMPC, 32'hFFFF_00AB);
    rd(TCW_OFF_CMPC, 32'h00AB, "cmp c capture");
    wr(TCW_OFF_MODE, 32'h8000);
    wr(TCW_OFF_CMPA, 32'hABCD_1234);
    rd(TCW_OFF_CMPA, 32'h1234, "cmp a wave");
    wr(TCW_OFF_CMPB, 32'h5678);
    rd(TCW_OFF_CMPB, 32'h5678, "cmp b wave");
    wr(TCW_OFF_COUNT, 32'h77);
    rd(TCW_OFF_COUNT, 32'h0, "count read only");
    $display("test regs done");
  endtask
  task automatic t_edge();
    for (int inv = 0; inv < 2; inv++) begin
      wr(TCW_OFF_MODE, 32'h8005 | (32'(inv) << TCW_M_CLKINV));
      wr(TCW_OFF_CTRL, 32'h5);
      rd(TCW_OFF_COUNT, 32'h0, "count after trigger");
      xc_req[0] <= 1'b1;
      repeat (8) @(posedge pclk);
      rd(TCW_OFF_COUNT, 32'(1 - inv), "count after rise");
      xc_req[0] <= 1'b0;
      repeat (8) @(posedge pclk);
      rd(TCW_OFF_COUNT, 32'h1, "count after fall");
    end
    $display("test edge done");
  endtask
  task automatic t_match();
    logic [31:0] r;
    logic        e;
    wr(TCW_OFF_CMPA, 32'h3);
    wr(TCW_OFF_CMPC, 32'h5);
    for (int b = TCW_M_STOP; b <= TCW_M_DIS; b++) begin
      wr(TCW_OFF_MODE, 32'h0009_8005 | (32'h1 << b));
      wr(TCW_OFF_CTRL, 32'h5);
      pulse(0, 3);
      chk("line a match a", 32'h1, 32'(a_o));
      chk("line a enable", 32'h0, 32'(a_oe_n));
      pulse(0, 2);
      chk("line a period", 32'h0, 32'(a_o));
      pulse(0, 2);
      rd(TCW_OFF_COUNT, 32'h5, "count held");
    end
    wr(TCW_OFF_CMPC, 32'h2);
    wr(TCW_OFF_MODE, 32'hC005);
    wr(TCW_OFF_CTRL, 32'h5);
    pulse(0, 7);
    apb(1'b0, TCW_OFF_COUNT, 32'h0, r, e);
    chk("count wraps", 32'h1, 32'(r < 32'h3));
    $display("test match done");
  endtask
  task automatic t_soft();
    wr(TCW_OFF_MODE, 32'h40C0_8405);
    for (int k = 0; k < 2; k++) begin
      wr(TCW_OFF_CTRL, 32'h4);
      repeat (3) @(posedge pclk);
      chk("line a soft", 32'(1 - k), 32'(a_o));
      chk("line b soft", 32'h1, 32'(b_o));
    end
    chk("line b driven", 32'h0, 32'(b_oe_n));
    $display("test soft done");
  endtask
  task automatic t_event();
    wr(TCW_OFF_MODE, 32'h2010_9905);
    wr(TCW_OFF_CTRL, 32'h1);
    pulse(0, 3);
    pulse(1, 1);
    rd(TCW_OFF_COUNT, 32'h0, "count after event");
    chk("line a event", 32'h1, 32'(a_o));
    chk("line b event", 32'h0, 32'(b_o));
    wr(TCW_OFF_MODE, 32'h0030_8205);
    repeat (4) @(posedge pclk);
    chk("line b released", 32'h1, 32'(b_oe_n));
    b_req <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("line a on rise", 32'h1, 32'(a_o));
    b_req <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("line a on fall", 32'h0, 32'(a_o));
    $display("test event done");
  endtask
  task automatic t_gate();
    wr(TCW_OFF_CMPB, 32'h2);
    wr(TCW_OFF_CMPC, 32'h4);
    wr(TCW_OFF_MODE, 32'h0900_8425);
    wr(TCW_OFF_CTRL, 32'h5);
    pulse(0, 2);
    rd(TCW_OFF_COUNT, 32'h0, "count gated off");
    xc_req[1] <= 1'b1;
    pulse(0, 2);
    chk("line b match b", 32'h1, 32'(b_o));
    pulse(0, 2);
    chk("line b period", 32'h0, 32'(b_o));
    rd(TCW_OFF_COUNT, 32'h4, "count gated on");
    xc_req[1] <= 1'b0;
    $display("test gate done");
  endtask
  // Reset for 16 cycles, then the scenarios in turn.
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, xc_req, b_req} <= '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_edge();
    t_match();
    t_soft();
    t_event();
    t_gate();
    tally_and_finish();
  end
endmodule
